// [rtl/ddrt_pkg.sv]
/*
  Shared constants and types for the memory-side bank timing block:
  command encodings, latency and timing figures, packed command and
  write-data carriers.
  Assumes one command clock of 200 MHz; the times below are in ps.
*/
package ddrt_pkg;

  // ==========================================================
  // command encodings
  // ==========================================================
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE,
    CMD_REF
  } ddrt_cmd_e_t;

  // ==========================================================
  // widths and geometry
  // ==========================================================
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int DQ_W = 16;
  localparam int PRE_SEL_BIT = 10;
  localparam int ADDR_W = 13;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PS = 5000;
  localparam int PREFETCH_LEAD = 2;
  localparam int BL4 = 4;
  localparam int BL8 = 8;
  localparam int LAT_W = 4;
  localparam int CNT_W = 5;
  localparam logic [LAT_W-1:0] WL_SHORTEN = 4'h1;

  typedef struct packed {
    ddrt_cmd_e_t cmd;
    logic [BA_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrt_cmd_t;

  typedef struct packed {
    logic valid;
    logic [BA_W-1:0] bank;
    logic [DQ_W-1:0] data;
  } ddrt_wdata_t;

endpackage

// [rtl/ddrt_wr_capture.sv]
/*
  Write data capture: takes data on each rising strobe sample during
  an open write window and closes the window once the burst is done.
  Assumes strobe and data are already sampled on clk.
*/
`timescale 1ns/100ps
`default_nettype none

module ddrt_wr_capture
  #(parameter int DQ_W = 16)
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // window control
  input wire logic winOpen,
  input wire logic [ddrt_pkg::CNT_W-1:0] beats,
  // strobe and data
  input wire logic strobe,
  input wire logic [DQ_W-1:0] dqIn,
  // captured data
  output logic [DQ_W-1:0] capData,
  output logic capValid,
  output logic capDone
  );

  logic strobePrev_r, strobePrev_nxt;
  logic [ddrt_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [DQ_W-1:0] capData_r, capData_nxt;
  logic capValid_r, capValid_nxt;
  logic active_r, active_nxt;
  logic rise;

  always_comb
  begin
    rise = strobe & ~strobePrev_r;
    strobePrev_nxt = strobe;
    cnt_nxt = cnt_r;
    capData_nxt = capData_r;
    capValid_nxt = 1'b0;
    active_nxt = active_r;
    if (winOpen && !active_r)
    begin
      active_nxt = 1'b1;
      cnt_nxt = beats;
    end
    if (active_r && rise && cnt_r != '0)
    begin
      capData_nxt = dqIn;
      capValid_nxt = 1'b1;
      cnt_nxt = cnt_r - 1'b1;
      if (cnt_r == 5'h01)
      begin
        active_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strobePrev_r <= 1'b0;
      cnt_r <= '0;
      capData_r <= '0;
      capValid_r <= 1'b0;
      active_r <= 1'b0;
    end
    else
    begin
      strobePrev_r <= strobePrev_nxt;
      cnt_r <= cnt_nxt;
      capData_r <= capData_nxt;
      capValid_r <= capValid_nxt;
      active_r <= active_nxt;
    end
  end

  assign capData = capData_r;
  assign capValid = capValid_r;
  assign capDone = ~active_r;

endmodule

`default_nettype wire

// [rtl/ddrt_bank_timing.sv]
/*
  Memory-side bank timing: per-bank open state, auto precharge launch,
  write latency and write window, manual precharge and
  self refresh tracking.
  Assumes a controller that keeps its own spacing limits; commands
  arrive decoded and synchronous to clk.
*/
// Behaviour
// - tRTP counts from last prefetch edge, AL after read for BL4
// - read with select bit high precharges AL+BL/2 clocks later
// - auto precharge never earlier than two clocks after last prefetch
// - write latency is read latency minus one clock
// - first data on first strobe rise, then successive rises
// - after write burst data pins stay off and data is ignored
// - manual precharge select bit picks one bank or all banks
`timescale 1ns/100ps
`default_nettype none

module ddrt_bank_timing
  #(parameter int BANKS = ddrt_pkg::BANKS,
    parameter int DQ_W = ddrt_pkg::DQ_W)
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // latency settings
  input wire logic [ddrt_pkg::LAT_W-1:0] addLat,
  input wire logic [ddrt_pkg::LAT_W-1:0] casLat,
  input wire logic burstEight,
  // command
  input wire logic cke,
  input wire ddrt_pkg::ddrt_cmd_t cmdIn,
  // write data
  input wire logic data_strobe_pair,
  input wire logic [DQ_W-1:0] dqIn,
  // state out
  output logic [BANKS-1:0] bankOpen,
  output logic [BANKS-1:0] autoPreStart,
  output logic selfRefresh,
  output logic dqOutEn,
  output ddrt_pkg::ddrt_wdata_t wrData
  );

  typedef enum {PW_IDLE, PW_WAIT, PW_BURST} ddrt_wst_t;

  logic [BANKS-1:0] open_r, open_nxt;
  logic [BANKS-1:0] apArm_r, apArm_nxt;
  logic [BANKS-1:0] apFire_r, apFire_nxt;
  logic [ddrt_pkg::CNT_W-1:0] apCnt_r [BANKS];
  logic [ddrt_pkg::CNT_W-1:0] apCnt_nxt [BANKS];
  ddrt_wst_t wst_r, wst_nxt;
  logic [ddrt_pkg::CNT_W-1:0] wlCnt_r, wlCnt_nxt;
  logic [ddrt_pkg::BA_W-1:0] wBank_r, wBank_nxt;
  logic wAuto_r, wAuto_nxt;
  logic sref_r, sref_nxt;
  logic ckePrev_r, ckePrev_nxt;
  logic winOpen;
  logic [ddrt_pkg::CNT_W-1:0] beats;
  logic [DQ_W-1:0] capData;
  logic capValid;
  logic capDone;
  logic [ddrt_pkg::CNT_W-1:0] apDelay;
  logic [ddrt_pkg::LAT_W-1:0] wl;
  logic selAll;

  // ==========================================================
  // derived latencies
  // ==========================================================
  // write latency one less than read
  assign wl = addLat + casLat - ddrt_pkg::WL_SHORTEN;
  assign beats = burstEight ? ddrt_pkg::CNT_W'(ddrt_pkg::BL8)
                            : ddrt_pkg::CNT_W'(ddrt_pkg::BL4);
  // AL plus BL/2 from the read command
  assign apDelay = ddrt_pkg::CNT_W'(addLat) + (beats >> 1);
  assign selAll = cmdIn.addr[ddrt_pkg::PRE_SEL_BIT];

  // ==========================================================
  // bank state and auto precharge
  // ==========================================================
  always_comb
  begin
    open_nxt = open_r;
    apArm_nxt = apArm_r;
    apFire_nxt = '0;
    for (int b = 0; b < BANKS; b++)
    begin
      apCnt_nxt[b] = apCnt_r[b];
      if (apArm_r[b])
      begin
        if (apCnt_r[b] <= 5'h01)
        begin
          apArm_nxt[b] = 1'b0;
          apFire_nxt[b] = 1'b1;
          open_nxt[b] = 1'b0;
        end
        else
        begin
          apCnt_nxt[b] = apCnt_r[b] - 1'b1;
        end
      end
    end
    if (cke && !sref_r)
    begin
      case (cmdIn.cmd)
        ddrt_pkg::CMD_ACT:
        begin
          open_nxt[cmdIn.bank] = 1'b1;
        end
        ddrt_pkg::CMD_RD:
        begin
          // read with auto precharge arms bank
          if (selAll)
          begin
            apArm_nxt[cmdIn.bank] = 1'b1;
            apCnt_nxt[cmdIn.bank] = apDelay;
          end
        end
        ddrt_pkg::CMD_PRE:
        begin
          if (selAll)
          begin
            open_nxt = '0;
          end
          else
          begin
            open_nxt[cmdIn.bank] = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // write with auto precharge closes bank after burst
    if (wst_r == PW_BURST && capDone && wAuto_r && !winOpen)
    begin
      open_nxt[wBank_r] = 1'b0;
      apFire_nxt[wBank_r] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      open_r <= '0;
      apArm_r <= '0;
      apFire_r <= '0;
      for (int b = 0; b < BANKS; b++)
      begin
        apCnt_r[b] <= '0;
      end
    end
    else
    begin
      open_r <= open_nxt;
      apArm_r <= apArm_nxt;
      apFire_r <= apFire_nxt;
      for (int b = 0; b < BANKS; b++)
      begin
        apCnt_r[b] <= apCnt_nxt[b];
      end
    end
  end

  // ==========================================================
  // write sequencing
  // ==========================================================
  always_comb
  begin
    wst_nxt = wst_r;
    wlCnt_nxt = wlCnt_r;
    wBank_nxt = wBank_r;
    wAuto_nxt = wAuto_r;
    winOpen = 1'b0;
    case (wst_r)
      PW_WAIT:
      begin
        if (wlCnt_r <= 5'h01)
        begin
          wst_nxt = PW_BURST;
          winOpen = 1'b1;
        end
        else
        begin
          wlCnt_nxt = wlCnt_r - 1'b1;
        end
      end
      PW_BURST:
      begin
        if (capDone)
        begin
          wst_nxt = PW_IDLE;
        end
      end
      default:
      begin
        wst_nxt = PW_IDLE;
      end
    endcase
    // a new write takes over an open burst
    if (cke && !sref_r && cmdIn.cmd == ddrt_pkg::CMD_WR)
    begin
      wst_nxt = PW_WAIT;
      wlCnt_nxt = ddrt_pkg::CNT_W'(wl);
      wBank_nxt = cmdIn.bank;
      wAuto_nxt = selAll;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wst_r <= PW_IDLE;
      wlCnt_r <= '0;
      wBank_r <= '0;
      wAuto_r <= 1'b0;
    end
    else
    begin
      wst_r <= wst_nxt;
      wlCnt_r <= wlCnt_nxt;
      wBank_r <= wBank_nxt;
      wAuto_r <= wAuto_nxt;
    end
  end

  ddrt_wr_capture #(.DQ_W(DQ_W)) uCapture (
    .clk(clk),
    .rst_n(rst_n),
    .winOpen(winOpen),
    .beats(beats),
    .strobe(data_strobe_pair),
    .dqIn(dqIn),
    .capData(capData),
    .capValid(capValid),
    .capDone(capDone)
  );

  // ==========================================================
  // self refresh
  // ==========================================================
  always_comb
  begin
    ckePrev_nxt = cke;
    sref_nxt = sref_r;
    if (ckePrev_r && !cke && cmdIn.cmd == ddrt_pkg::CMD_REF && open_r == '0)
    begin
      sref_nxt = 1'b1;
    end
    else if (!ckePrev_r && cke)
    begin
      sref_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sref_r <= 1'b0;
      ckePrev_r <= 1'b1;
    end
    else
    begin
      sref_r <= sref_nxt;
      ckePrev_r <= ckePrev_nxt;
    end
  end

  assign bankOpen = open_r;
  assign autoPreStart = apFire_r;
  assign selfRefresh = sref_r;
  // write path never drives data pins
  assign dqOutEn = 1'b0;
  assign wrData = '{valid: capValid, bank: wBank_r, data: capData};

endmodule

`default_nettype wire

// [sim/ddrt_bank_timing_checker.sv]
/*
  Port checker for the bank timing block.
  Assumes binding onto ddrt_bank_timing with its parameters.
*/
`timescale 1ns/100ps
`default_nettype none

module ddrt_bank_timing_checker
  #(parameter int BANKS = 8,
    parameter int DQ_W = 16)
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command side
  input wire logic cke,
  input wire ddrt_pkg::ddrt_cmd_t cmdIn,
  // block outputs
  input wire logic [BANKS-1:0] bankOpen,
  input wire logic [BANKS-1:0] autoPreStart,
  input wire logic selfRefresh,
  input wire logic dqOutEn,
  input wire ddrt_pkg::ddrt_wdata_t wrData
  );
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // command sequences
  // ==========================================================
  sequence takenPre;
    cke && !selfRefresh && cmdIn.cmd == ddrt_pkg::CMD_PRE;
  endsequence
  sequence takenAct;
    cke && !selfRefresh && cmdIn.cmd == ddrt_pkg::CMD_ACT;
  endsequence
  sequence srEnter;
    $past(cke) && !cke && !selfRefresh && cmdIn.cmd == ddrt_pkg::CMD_REF && bankOpen == '0;
  endsequence

  // ==========================================================
  // assertions
  // ==========================================================
  data_off_a: assert property (dqOutEn == 1'b0)
    else $error("data pins enabled");
  valid_pulse_a: assert property (wrData.valid |=> !wrData.valid)
    else $error("capture valid held");
  autopre_pulse_a: assert property (|autoPreStart |=> (autoPreStart & $past(autoPreStart)) == '0)
    else $error("auto precharge pulse held");
  autopre_close_a: assert property (|autoPreStart |-> (autoPreStart & bankOpen) == '0)
    else $error("bank open at auto precharge");
  pre_one_a: assert property (takenPre ##0 !cmdIn.addr[ddrt_pkg::PRE_SEL_BIT]
    |=> !bankOpen[$past(cmdIn.bank)])
    else $error("single precharge left bank open");
  pre_all_a: assert property (takenPre ##0 cmdIn.addr[ddrt_pkg::PRE_SEL_BIT] |=> bankOpen == '0)
    else $error("precharge all left a bank open");
  act_open_a: assert property (takenAct |=> bankOpen[$past(cmdIn.bank)])
    else $error("activate did not open bank");
  sref_entry_a: assert property (srEnter |=> selfRefresh)
    else $error("self refresh not entered");
  sref_exit_a: assert property (selfRefresh && cke |=> !selfRefresh)
    else $error("self refresh not left");
endmodule

bind ddrt_bank_timing ddrt_bank_timing_checker #(.BANKS(BANKS), .DQ_W(DQ_W))
  u_ddrt_bank_timing_checker (.clk, .rst_n, .cke, .cmdIn, .bankOpen, .autoPreStart,
  .selfRefresh, .dqOutEn, .wrData);
`default_nettype wire

// [sim/ddrt_ctrl_model.sv]
/*
  Controller write side model: strobe preamble, one rise per beat.
  Assumes go is high with the write command; one extra late rise.
*/
`timescale 1ns/100ps
`default_nettype none

module ddrt_ctrl_model
  (
  // clock and control
  input wire logic clk,
  input wire logic go,
  input wire logic [4:0] wl,
  input wire logic [4:0] beats,
  // strobe and data
  output logic strobe,
  output logic [15:0] dq
  );
  int j = 99;
  int b;
  logic on;

  always @(posedge clk)
  begin
    j = go ? 1 : j + 1;
    b = (j - wl - 1) / 2;
    on = (j > wl) && ((j - wl) % 2 == 1) && (b <= beats);
    #1;
    strobe = on;
    dq = on ? 16'hA000 + b[15:0] : ~dq;
  end

  initial
  begin
    strobe = 1'b0;
    dq = 16'h0000;
  end
endmodule
`default_nettype wire

// [sim/ddrt_bank_timing_test.sv]
/*
  Testbench for the bank timing block: precharge, auto precharge,
  write capture and self refresh scenarios.
  Assumes the controller model for strobe and write data.
*/
`timescale 1ns/100ps
`default_nettype none

module ddrt_bank_timing_test;
  logic clk, rst_n, burstEight, cke, strobe, selfRefresh, dqOutEn;
  // idle span that covers precharge recovery before a bank is reused
  localparam int GAP_CYC = 8;
  logic [3:0] addLat, casLat;
  logic [4:0] wl, beats;
  logic [15:0] dq;
  logic [7:0] bankOpen, autoPreStart;
  ddrt_pkg::ddrt_cmd_t cmdIn;
  ddrt_pkg::ddrt_wdata_t wrData;
  int fails = 0;
  int checks_done = 0;

  ddrt_bank_timing u_ddrt_bank_timing (.clk(clk), .rst_n(rst_n), .addLat(addLat),
    .casLat(casLat), .burstEight(burstEight), .cke(cke), .cmdIn(cmdIn),
    .data_strobe_pair(strobe), .dqIn(dq), .bankOpen(bankOpen),
    .autoPreStart(autoPreStart), .selfRefresh(selfRefresh), .dqOutEn(dqOutEn),
    .wrData(wrData));
  ddrt_ctrl_model u_ddrt_ctrl_model (.clk(clk), .go(cmdIn.cmd == ddrt_pkg::CMD_WR),
    .wl(wl), .beats(beats),
    .strobe(strobe), .dq(dq));

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic issue(ddrt_pkg::ddrt_cmd_e_t c, logic [2:0] b, logic [12:0] a = 13'h0000);
    cmdIn = '{c, b, a};
    @(posedge clk);
    #1;
    cmdIn = '{ddrt_pkg::CMD_NOP, 3'h0, 13'h0000};
    // one idle edge keeps back-to-back calls apart
    @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("fails %0d checks_done %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_pre();
    issue(ddrt_pkg::CMD_ACT, 3'h1);
    issue(ddrt_pkg::CMD_ACT, 3'h2);
    issue(ddrt_pkg::CMD_ACT, 3'h6);
    issue(ddrt_pkg::CMD_PRE, 3'h2);
    cmp("preOne", 16'h0042, bankOpen);
    issue(ddrt_pkg::CMD_PRE, 3'h5, 13'h0400);
    cmp("preAll", 16'h0000, bankOpen);
  endtask

  task automatic t_rdap(logic [3:0] al, logic be);
    int k;
    addLat = al;
    burstEight = be;
    issue(ddrt_pkg::CMD_ACT, 3'h5);
    issue(ddrt_pkg::CMD_RD, 3'h5, 13'h0400);
    k = 1;
    while (autoPreStart[5] !== 1'b1 && k < 40)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp("autoPreDelay", al + (be ? 4 : 2), k);
    cmp("autoPreClosed", 16'h0000, bankOpen);
    // idle span before the next command
    repeat (GAP_CYC) @(posedge clk);
    #1;
  endtask

  task automatic t_write(logic [3:0] al, logic [3:0] cl, logic be, logic [2:0] bk, logic ap);
    int n;
    int pulses;
    addLat = al;
    casLat = cl;
    burstEight = be;
    // write latency one under read latency
    wl = {1'b0, al} + {1'b0, cl} - 5'h01;
    beats = be ? 5'h08 : 5'h04;
    issue(ddrt_pkg::CMD_ACT, bk);
    issue(ddrt_pkg::CMD_WR, bk, ap ? 13'h0400 : 13'h0000);
    n = 0;
    pulses = 0;
    // k counts edges from the one that takes the write
    for (int k = 1; k <= 40; k++)
    begin
      if (wrData.valid === 1'b1)
      begin
        if (n == 0)
          cmp("firstBeatCycle", wl + 5'h01, k);
        cmp("beatData", 16'hA000 + n, wrData.data);
        cmp("beatBank", bk, wrData.bank);
        n++;
      end
      if (autoPreStart[bk] === 1'b1)
        pulses++;
      @(posedge clk);
      #1;
    end
    cmp("beatCount", beats, n);
    cmp("wrAutoPre", ap, pulses);
    cmp("wrBankOpen", !ap, bankOpen[bk]);
    // next command comes well after the burst
  endtask

  task automatic t_sref();
    issue(ddrt_pkg::CMD_PRE, 3'h0, 13'h0400);
    repeat (GAP_CYC) @(posedge clk);
    #1;
    cke = 1'b0;
    issue(ddrt_pkg::CMD_REF, 3'h0);
    cmp("srEnter", 16'h0001, selfRefresh);
    issue(ddrt_pkg::CMD_ACT, 3'h3);
    cmp("srIgnore", 16'h0000, bankOpen);
    @(posedge clk);
    #1;
    cke = 1'b1;
    @(posedge clk);
    #1;
    cmp("srExit", 16'h0000, selfRefresh);
    repeat (200) @(posedge clk);
    #1;
    issue(ddrt_pkg::CMD_ACT, 3'h3);
    cmp("actAfterExit", 16'h0008, bankOpen);
  endtask

  // ==========================================================
  // clock, main sequence, watchdog
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    cke = 1'b1;
    addLat = 4'h0;
    casLat = 4'h3;
    burstEight = 1'b0;
    wl = 5'h02;
    beats = 5'h04;
    cmdIn = '{ddrt_pkg::CMD_NOP, 3'h0, 13'h0000};
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // whole run is shorter than one refresh interval
    t_pre();
    t_rdap(4'h0, 1'b0);
    t_rdap(4'h2, 1'b1);
    t_rdap(4'h1, 1'b0);
    t_write(4'h0, 4'h3, 1'b0, 3'h1, 1'b0);
    t_write(4'h1, 4'h4, 1'b1, 3'h2, 1'b1);
    t_sref();
    print_verdict();
  end

  initial
  begin
    #10000;
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
